// ===== gas_alarm_state_output_control.sv
/*
 * Supervisory state, lamp, display and 4-20 mA level selection of a gas
 * detector head, with a classic Wishbone register slave.
 * Assumes the concentration, temperature and fault inputs are synchronous
 * to clk_i, and that an analog stage turns loop_level_o into current.
 */
`timescale 1ns/1ps

// Functional notes
// RQ1 - User mode times out after ten hours
// RQ2 - Failed zero: FAIL, menu 1-1, keep zero
// RQ3 - Alarm when concentration at or above setpoint
// RQ4 - Two second alarm delay, can disable
// RQ5 - Alarm self-clears below setpoint
// RQ6 - Red lamp follows alarm condition
// RQ7 - Green power lamp always lit
// RQ8 - Fault raises yellow lamp and error code
// RQ9 - Fault clear restarts with initial clear
// RQ10 - Over temperature alternates display with E-27
// RQ11 - Over temperature keeps loop, fault lamp dark
// RQ12 - Point-skip hold drives configurable fixed level
// RQ13 - Alarm test: proportional or fixed 4 mA
// RQ14 - User mode keeps proportional loop output
// RQ15 - Gas alarm keeps proportional loop output
// RQ16 - Over full scale clamps at 20.5 mA
// RQ17 - Suppress readings below threshold to zero
// RQ18 - Zero adjustment bypasses suppression
// RQ19 - Suppression off: linear down to 4 mA
// RQ20 - Ten percent below zero shows -0.0
// RQ21 - Loop priority: fault, hold, clamp, proportional
module gas_alarm_state_output_control #(
    parameter int CYCLES_PER_MS_P = gas_head_pkg::CYCLES_PER_MS,
    parameter int USER_TIMEOUT_MS_P = gas_head_pkg::USER_TIMEOUT_MS,
    parameter int INIT_CLEAR_MS_P = gas_head_pkg::INIT_CLEAR_MS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input gas_head_pkg::wb_req_type wb_req_i,
    output gas_head_pkg::wb_rsp_type wb_rsp_o,
    input wire logic signed [15:0] raw_conc_i,
    input wire logic temp_out_of_range_i,
    input wire logic fault_i,
    input wire logic [7:0] fault_code_i,
    input wire logic exit_key_i,
    input wire logic zero_take_i,
    output gas_head_pkg::panel_type panel_o,
    output logic gas_alarm_o,
    output logic [7:0] loop_level_o
);
    import gas_head_pkg::*;

    // ************
    // State
    // ************
    typedef struct packed {
        state_type state;
        logic [3:0] ctrl;
        logic [15:0] setpoint;
        logic [15:0] supp_thr;
        logic [7:0] inh_level;
        logic signed [15:0] zero;
        logic [31:0] ms_cnt;
        logic [15:0] blink_cnt;
        logic blink;
        logic zero_failed;
        logic zero_passed;
        logic ack;
        logic [31:0] rdat;
        panel_type panel;
        logic [7:0] loop;
    } ctl_state_type;

    ctl_state_type s_q, s_d;
    logic tick;
    logic alarm;
    logic signed [15:0] conc;
    logic signed [15:0] drift;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] loop_prop;
    logic [10:0] conc_pos;

    // Byte lane merge for a 32-bit register word
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] wdat,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // True when the key returns the head to detection
    function automatic logic in_menu(input state_type st);
        return (st == ST_USER) || (st == ST_MAINT) ||
               (st == ST_TEST) || (st == ST_ZERO);
    endfunction

    // ************
    // Helpers
    // ************
    ms_tick #(
        .CYCLES(CYCLES_PER_MS_P)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    alarm_qualifier u_alarm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .delay_en_i(s_q.ctrl[CTRL_DELAY_EN]),
        .conc_i(conc),
        .setpoint_i(s_q.setpoint),
        .alarm_o(alarm)
    );

    // Zero-corrected reading and the proportional loop level
    assign conc = raw_conc_i - s_q.zero;
    assign drift = (raw_conc_i < 0) ? -raw_conc_i : raw_conc_i;
    assign wr_stb = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & s_q.ack;
    assign rd_stb = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & ~s_q.ack;

    // Negative readings sit at the 4 mA floor
    always_comb begin
        conc_pos = 11'h0;
        if (conc > 0 && conc <= FULL_SCALE) begin
            conc_pos = conc[10:0];
        end
        if (s_q.ctrl[CTRL_SUPP_EN] && conc < $signed(s_q.supp_thr)) begin
            conc_pos = 11'h0;
        end
    end

    // RQ19 - linear 4 to 20 mA
    assign loop_prop = LOOP_4MA + 8'(conc_pos / 11'd10);

    // ************
    // Next state
    // ************
    always_comb begin
        s_d = s_q;
        s_d.ack = wb_req_i.cyc & wb_req_i.stb & ~s_q.ack;

        // Register writes take effect once, on the acked cycle
        if (wr_stb) begin
            case (wb_req_i.adr)
                REG_CTRL: begin
                    s_d.ctrl = 4'(lane_merge(32'(s_q.ctrl), wb_req_i.dat,
                                             wb_req_i.sel));
                end
                REG_SETPOINT: begin
                    s_d.setpoint = 16'(lane_merge(32'(s_q.setpoint),
                                                  wb_req_i.dat,
                                                  wb_req_i.sel));
                end
                REG_SUPP_THR: begin
                    s_d.supp_thr = 16'(lane_merge(32'(s_q.supp_thr),
                                                  wb_req_i.dat,
                                                  wb_req_i.sel));
                end
                REG_INH_LEVEL: begin
                    s_d.inh_level = 8'(lane_merge(32'(s_q.inh_level),
                                                  wb_req_i.dat,
                                                  wb_req_i.sel));
                end
                default: begin
                end
            endcase
        end

        // Read data, unmapped offsets read zero
        if (rd_stb) begin
            case (wb_req_i.adr)
                REG_CTRL: s_d.rdat = 32'(s_q.ctrl);
                REG_SETPOINT: s_d.rdat = 32'(s_q.setpoint);
                REG_SUPP_THR: s_d.rdat = 32'(s_q.supp_thr);
                REG_INH_LEVEL: s_d.rdat = 32'(s_q.inh_level);
                REG_STATUS: begin
                    s_d.rdat = {22'h0, s_q.zero_passed, s_q.zero_failed,
                                temp_out_of_range_i, fault_i, alarm,
                                s_q.state, 2'h0};
                end
                REG_ZERO: s_d.rdat = 32'(unsigned'(s_q.zero));
                REG_OUTPUT: s_d.rdat = {24'h0, s_q.loop};
                default: s_d.rdat = 32'h0;
            endcase
        end

        // Alternation clock for the temperature warning
        if (tick) begin
            if (s_q.blink_cnt == 16'(BLINK_MS - 1)) begin
                s_d.blink_cnt = 16'h0;
                s_d.blink = ~s_q.blink;
            end else begin
                s_d.blink_cnt = s_q.blink_cnt + 16'h1;
            end
        end
        if (tick) begin
            s_d.ms_cnt = s_q.ms_cnt + 32'h1;
        end

        // Operating state; a fault preempts every other state
        case (s_q.state)
            ST_INIT: begin
                if (s_q.ms_cnt >= 32'(INIT_CLEAR_MS_P)) begin
                    s_d.state = ST_DETECT;
                end
            end
            ST_FAULT: begin
                // RQ9 - restart via initial clear
                if (!fault_i) begin
                    s_d.state = ST_INIT;
                    s_d.ms_cnt = 32'h0;
                end
            end
            ST_DETECT: begin
                if (wr_stb && wb_req_i.adr == REG_MODE_CMD &&
                    wb_req_i.sel[0]) begin
                    case (wb_req_i.dat[2:0])
                        ST_USER, ST_MAINT, ST_TEST, ST_ZERO: begin
                            s_d.state = state_type'(wb_req_i.dat[2:0]);
                            s_d.ms_cnt = 32'h0;
                            s_d.zero_failed = 1'b0;
                            s_d.zero_passed = 1'b0;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_USER, ST_MAINT, ST_TEST, ST_ZERO: begin
                if (exit_key_i) begin
                    s_d.state = ST_DETECT;
                end else if (s_q.ms_cnt >= 32'(USER_TIMEOUT_MS_P)) begin
                    // RQ1 - timed return to detection
                    s_d.state = ST_DETECT;
                end
                if (s_q.state == ST_ZERO && zero_take_i) begin
                    if (drift > ZERO_DRIFT_LIMIT) begin
                        // RQ2 - fail keeps previous zero
                        s_d.zero_failed = 1'b1;
                        s_d.zero_passed = 1'b0;
                    end else begin
                        s_d.zero = raw_conc_i;
                        s_d.zero_passed = 1'b1;
                        s_d.zero_failed = 1'b0;
                    end
                end
            end
            default: begin
                s_d.state = ST_INIT;
                s_d.ms_cnt = 32'h0;
            end
        endcase
        if (fault_i) begin
            s_d.state = ST_FAULT;
        end
        if (!in_menu(s_d.state) && in_menu(s_q.state)) begin
            s_d.ms_cnt = 32'h0;
        end

        // ************
        // Panel
        // ************
        // RQ7 - power lamp steady on
        s_d.panel.power_lamp = 1'b1;
        // RQ6 - red lamp with alarm
        s_d.panel.gas_alarm_lamp = alarm;
        // RQ8 - fault lamp and code
        s_d.panel.fault_lamp = (s_q.state == ST_FAULT);
        s_d.panel.fault_code = (s_q.state == ST_FAULT) ? fault_code_i
                                                        : 8'h00;
        // RQ2 - back to item 1-1
        s_d.panel.menu_item = (s_q.state == ST_ZERO) ? MENU_ZERO_ADJ
                                                      : MENU_NONE;
        s_d.panel.value = unsigned'(conc);
        s_d.panel.show = SHOW_CONC;
        if (conc <= NEG_LIMIT) begin
            // RQ20 - far below zero pattern
            s_d.panel.show = SHOW_NEG_ZERO;
            s_d.panel.value = 16'h0;
        end else if (s_q.state == ST_ZERO) begin
            // RQ18 - unsuppressed zero-corrected reading while zeroing
            s_d.panel.value = unsigned'(conc);
            if (s_q.zero_failed) begin
                s_d.panel.show = SHOW_FAIL;
            end else if (s_q.zero_passed) begin
                s_d.panel.show = SHOW_PASS;
            end
        end else if (s_q.ctrl[CTRL_SUPP_EN] &&
                     conc < $signed(s_q.supp_thr)) begin
            // RQ17 - suppressed to zero
            s_d.panel.value = 16'h0;
        end
        if (s_q.state == ST_FAULT) begin
            s_d.panel.show = SHOW_ERROR;
        end else if (temp_out_of_range_i && s_q.blink) begin
            // RQ10 - alternate with E-27
            s_d.panel.show = SHOW_WARN_E27;
        end

        // ************
        // Loop level; over temperature never enters this choice
        // ************
        // RQ21 - fault, hold, clamp, proportional
        if (s_q.state == ST_FAULT) begin
            s_d.loop = LOOP_FAULT;
        end else if (s_q.state == ST_INIT) begin
            s_d.loop = LOOP_INIT;
        end else if (s_q.state == ST_MAINT || s_q.state == ST_ZERO ||
                     s_q.ctrl[CTRL_INHIBIT]) begin
            // RQ12 - configurable hold level
            s_d.loop = s_q.inh_level;
        end else if (s_q.state == ST_TEST &&
                     !s_q.ctrl[CTRL_TEST_OUT]) begin
            // RQ13 - test output off
            s_d.loop = LOOP_4MA;
        end else if (conc > FULL_SCALE) begin
            // RQ16 - clamp at 20.5 mA
            s_d.loop = LOOP_OVER;
        end else begin
            // RQ11 RQ14 RQ15 - stays proportional
            s_d.loop = loop_prop;
        end
    end

    // ************
    // Registers
    // ************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.state <= ST_INIT;
            s_q.ctrl <= CTRL_RST;
            s_q.setpoint <= SETPOINT_RST;
            s_q.supp_thr <= SUPP_THR_RST;
            s_q.inh_level <= LOOP_INHIBIT_RST;
            s_q.panel.power_lamp <= 1'b1;
            s_q.panel.show <= SHOW_CONC;
            s_q.loop <= LOOP_INIT;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_rsp_o.ack = s_q.ack;
    assign wb_rsp_o.dat = s_q.rdat;
    assign panel_o = s_q.panel;
    assign gas_alarm_o = alarm;
    assign loop_level_o = s_q.loop;
endmodule // gas_alarm_state_output_control

// ===== gas_head_pkg.sv
/*
 * Shared constants and carrier types of the gas detector supervisory block.
 * Assumes a single 40 MHz clock and a 32-bit classic Wishbone register bus.
 */
package gas_head_pkg;

    // ************
    // Timing
    // ************
    localparam int CLK_HZ = 40000000;
    localparam int TICK_MS = 1;
    localparam int CYCLES_PER_MS = CLK_HZ / 1000 * TICK_MS;
    localparam int ALARM_DELAY_S = 2;
    localparam int ALARM_DELAY_MS = ALARM_DELAY_S * 1000;
    localparam int USER_TIMEOUT_H = 10;
    localparam int USER_TIMEOUT_MS = USER_TIMEOUT_H * 3600 * 1000;
    localparam int INIT_CLEAR_MS = 5000;
    localparam int BLINK_MS = 1000;

    // ************
    // Concentration scale (counts) and loop levels (units of 0.1 mA)
    // ************
    localparam logic signed [15:0] FULL_SCALE = 16'sd1600;
    localparam logic signed [15:0] NEG_LIMIT = -16'sd160;
    localparam logic signed [15:0] ZERO_DRIFT_LIMIT = 16'sd160;
    localparam logic [15:0] SUPP_THR_RST = 16'h0050;
    localparam logic [15:0] SETPOINT_RST = 16'h0190;
    localparam logic [7:0] LOOP_FAULT = 8'h05;
    localparam logic [7:0] LOOP_INIT = 8'h19;
    localparam logic [7:0] LOOP_INHIBIT_RST = 8'h19;
    localparam logic [7:0] LOOP_4MA = 8'h28;
    localparam logic [7:0] LOOP_OVER = 8'hcd;
    localparam logic [7:0] MENU_ZERO_ADJ = 8'h11;
    localparam logic [7:0] MENU_NONE = 8'h00;

    // ************
    // Register map (byte addresses) and control fields
    // ************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MODE_CMD = 8'h04;
    localparam logic [7:0] REG_SETPOINT = 8'h08;
    localparam logic [7:0] REG_SUPP_THR = 8'h0c;
    localparam logic [7:0] REG_INH_LEVEL = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_ZERO = 8'h18;
    localparam logic [7:0] REG_OUTPUT = 8'h1c;
    localparam int CTRL_DELAY_EN = 0;
    localparam int CTRL_SUPP_EN = 1;
    localparam int CTRL_TEST_OUT = 2;
    localparam int CTRL_INHIBIT = 3;
    localparam logic [3:0] CTRL_RST = 4'h3;

    typedef enum logic [2:0] {
        ST_INIT = 3'b000,
        ST_DETECT = 3'b001,
        ST_USER = 3'b010,
        ST_MAINT = 3'b011,
        ST_TEST = 3'b100,
        ST_ZERO = 3'b101,
        ST_FAULT = 3'b110
    } state_type;

    typedef enum logic [2:0] {
        SHOW_CONC = 3'b000,
        SHOW_WARN_E27 = 3'b001,
        SHOW_NEG_ZERO = 3'b010,
        SHOW_PASS = 3'b011,
        SHOW_FAIL = 3'b100,
        SHOW_ERROR = 3'b101
    } show_type;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_type;

    typedef struct packed {
        logic power_lamp;
        logic gas_alarm_lamp;
        logic fault_lamp;
        show_type show;
        logic [15:0] value;
        logic [7:0] fault_code;
        logic [7:0] menu_item;
    } panel_type;

endpackage

// ===== ms_tick.sv
/*
 * Millisecond enable divider.
 * Assumes one free-running clock; emits a one-cycle enable.
 */
`timescale 1ns/1ps
module ms_tick #(
    parameter int CYCLES = 40000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic tick_o
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } tick_state_type;

    tick_state_type s_q, s_d;

    // Count up a full millisecond, pulse at wrap
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == 32'(CYCLES - 1)) begin
            s_d.cnt = 32'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_o = s_q.tick;
endmodule // ms_tick

// ===== alarm_qualifier.sv
/*
 * Gas alarm comparator with optional qualification delay, auto-reset.
 * Assumes a millisecond enable from the shared divider.
 */
`timescale 1ns/1ps
module alarm_qualifier (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic delay_en_i,
    input wire logic signed [15:0] conc_i,
    input wire logic signed [15:0] setpoint_i,
    output logic alarm_o
);
    import gas_head_pkg::*;

    typedef struct packed {
        logic [15:0] ms;
        logic alarm;
    } qual_state_type;

    qual_state_type s_q, s_d;
    logic at_or_above;

    // RQ3 - compare at or above
    assign at_or_above = (conc_i >= setpoint_i);

    always_comb begin
        s_d = s_q;
        if (!at_or_above) begin
            // RQ5 - clears without operator
            s_d.alarm = 1'b0;
            s_d.ms = 16'h0;
        end else if (!delay_en_i) begin
            // RQ4 - delay can be off
            s_d.alarm = 1'b1;
        end else if (s_q.ms >= 16'(ALARM_DELAY_MS)) begin
            // RQ4 - qualified after delay
            s_d.alarm = 1'b1;
        end else if (tick_i) begin
            s_d.ms = s_q.ms + 16'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign alarm_o = s_q.alarm;
endmodule // alarm_qualifier

// ===== gas_alarm_state_output_control_monitor.sv
/* Checker of the gas head supervisory block's port behaviour.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module gas_alarm_state_output_control_monitor
    import gas_head_pkg::*;
#(
    parameter int CYCLES_PER_MS_P = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input gas_head_pkg::wb_req_type wb_req_i,
    input gas_head_pkg::wb_rsp_type wb_rsp_o,
    input wire logic signed [15:0] raw_conc_i,
    input wire logic temp_out_of_range_i,
    input wire logic fault_i,
    input gas_head_pkg::panel_type panel_o,
    input wire logic gas_alarm_o,
    input wire logic [7:0] loop_level_o
);
    // ************
    // Shadow state
    // ************
    logic signed [15:0] sp_q;
    logic [3:0] ctrl_q;
    int hi_q;
    logic wr;
    assign wr = wb_rsp_o.ack && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we;
    // Bus snoop at the write's ack edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sp_q <= SETPOINT_RST;
            ctrl_q <= CTRL_RST;
        end else if (wr && wb_req_i.adr == REG_SETPOINT)
            sp_q <= wb_req_i.dat[15:0];
        else if (wr && wb_req_i.adr == REG_CTRL)
            ctrl_q <= wb_req_i.dat[3:0];
    end
    // Cycles the reading has stayed at or above the setpoint
    always_ff @(posedge clk_i) begin
        if (rst_i || raw_conc_i < sp_q)
            hi_q <= 0;
        else if (hi_q < 1000000)
            hi_q <= hi_q + 1;
    end

    // ************
    // Properties
    // ************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    power_lamp_on_a: assert property (panel_o.power_lamp)
        else $error("power lamp dark");
    bus_ack_a: assert property (wb_req_i.cyc && wb_req_i.stb
        && !wb_rsp_o.ack |=> wb_rsp_o.ack) else $error("bus not acked");
    fault_loop_a: assert property (fault_i [*4] |->
        loop_level_o == LOOP_FAULT && panel_o.fault_lamp)
        else $error("fault output wrong");
    alarm_clear_a: assert property (raw_conc_i < sp_q [*4]
        |-> !gas_alarm_o) else $error("alarm not cleared");
    alarm_fast_a: assert property (!ctrl_q[CTRL_DELAY_EN]
        && !fault_i && raw_conc_i >= sp_q [*3] |-> gas_alarm_o)
        else $error("alarm missing");
    delay_hold_a: assert property ($rose(gas_alarm_o)
        && ctrl_q[CTRL_DELAY_EN] |-> hi_q >= 1999 * CYCLES_PER_MS_P)
        else $error("alarm came early");
    lamp_follow_a: assert property (panel_o.gas_alarm_lamp
        == $past(gas_alarm_o)) else $error("alarm lamp mismatch");
    temp_lamp_a: assert property (temp_out_of_range_i && !fault_i
        [*4] |-> !panel_o.fault_lamp) else $error("fault lamp lit");
    neg_zero_a: assert property (raw_conc_i <= NEG_LIMIT
        && !fault_i && !temp_out_of_range_i [*3]
        |-> panel_o.show == SHOW_NEG_ZERO) else $error("no -0.0");
endmodule // gas_alarm_state_output_control_monitor

// ===== loop_receiver.sv
/* Behavioural central receiver of the 4-20 mA loop.
   Assumes loop levels in 0.1 mA units, sampled on clk_i. */
`timescale 1ns/1ps
module loop_receiver (
    input wire logic clk_i,
    input wire logic [7:0] loop_level_i,
    output logic [15:0] conc_o,
    output logic fault_o
);
    // Below 1 mA the head reads as broken; 4 mA is zero reading
    always_ff @(posedge clk_i) begin
        fault_o <= loop_level_i < 8'h0a;
        conc_o <= (loop_level_i > 8'h28) ?
            16'((loop_level_i - 8'h28) * 10) : 16'h0000;
    end
endmodule // loop_receiver

// ===== test_gas_alarm_state_output_control.sv
/* Self-checking bench of the gas head supervisory block.
   Assumes package, design, receiver and checker compiled first. */
`timescale 1ns/1ps
module test_gas_alarm_state_output_control;
    import gas_head_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    wb_req_type req = '0;
    wb_rsp_type rsp;
    panel_type pnl;
    logic signed [15:0] raw = 16'sh0000;
    logic temp = 1'b0;
    logic flt = 1'b0;
    logic key = 1'b0;
    logic take = 1'b0;
    logic alarm;
    logic [7:0] loop;
    logic [15:0] rx_conc;
    logic rx_flt;
    logic [31:0] seed = 32'h00000038;
    logic [63:0] notes[$];
    int bad_count = 0;
    int tests_run = 0;
    int c;
    int n;

    // ************
    // Clock, design and receiver
    // ************
    always #12.5 clk_i = ~clk_i;
    gas_alarm_state_output_control #(.CYCLES_PER_MS_P(4),
        .USER_TIMEOUT_MS_P(50), .INIT_CLEAR_MS_P(3)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .raw_conc_i(raw), .temp_out_of_range_i(temp), .fault_i(flt),
        .fault_code_i(8'h27), .exit_key_i(key), .zero_take_i(take),
        .panel_o(pnl), .gas_alarm_o(alarm), .loop_level_o(loop));
    loop_receiver i_rx (.clk_i(clk_i), .loop_level_i(loop),
        .conc_o(rx_conc), .fault_o(rx_flt));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // One classic cycle; a read files its expected word first
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] m = '1);
        n = 0;
        if (!we)
            notes.push_back({m, d});
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, we, 4'hf, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 20);
        if (n >= 20)
            chk(32'h0, 32'h1);
        req <= '0;
    endtask
    // Read data is judged at the ack edge, oldest note first
    always @(posedge clk_i) begin
        if (rsp.ack === 1'b1 && req.we === 1'b0 && notes.size() > 0) begin
            chk(rsp.dat & notes[0][63:32], notes[0][31:0]);
            void'(notes.pop_front());
        end
    end
    task automatic put(input logic signed [15:0] v);
        @(posedge clk_i);
        raw <= v;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic lv(input logic [7:0] e);
        repeat (3) @(posedge clk_i);
        chk(loop, e);
        wb(1'b0, REG_OUTPUT, e);
    endtask
    task automatic pulse(input int k);
        @(posedge clk_i);
        if (k == 0) key <= 1'b1; else take <= 1'b1;
        @(posedge clk_i);
        key <= 1'b0;
        take <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ************
    // Scenarios
    // ************
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(pnl.power_lamp, 32'h1);
        wb(1'b0, REG_CTRL, 32'h3);
        wb(1'b0, REG_SETPOINT, 32'h190);
        wb(1'b0, 8'h20, 32'h0);
        repeat (20) @(posedge clk_i);
        wb(1'b0, REG_STATUS, 32'h4, 32'h1c);
        wb(1'b1, REG_CTRL, 32'h0);
        for (int i = 0; i < 8; i++) begin
            c = int'(xs() % 32'd1601);
            put(16'(c));
            lv(8'(40 + c / 10));
        end
        put(16'sh0000);
        lv(LOOP_4MA);
        put(16'sh0190);
        chk(alarm, 32'h1);
        chk(pnl.gas_alarm_lamp, 32'h1);
        lv(8'd80);
        put(16'sh018f);
        chk(alarm, 32'h0);
        chk(pnl.gas_alarm_lamp, 32'h0);
        put(16'sh06a4);
        lv(LOOP_OVER);
        wb(1'b1, REG_CTRL, 32'h2);
        put(16'sh0032);
        chk(pnl.value, 32'h0);
        put(-16'sh00a0);
        chk(pnl.show, SHOW_NEG_ZERO);
        temp <= 1'b1;
        put(16'sh012c);
        chk(pnl.fault_lamp, 32'h0);
        lv(8'd70);
        chk(rx_conc, 32'd300);
        for (n = 0; pnl.show !== SHOW_WARN_E27 && n < 9000; n++)
            @(posedge clk_i);
        chk(pnl.show, SHOW_WARN_E27);
        temp <= 1'b0;
        wb(1'b1, REG_INH_LEVEL, 32'd30);
        wb(1'b1, REG_CTRL, 32'ha);
        lv(8'd30);
        wb(1'b1, REG_CTRL, 32'h2);
        wb(1'b1, REG_MODE_CMD, 32'h4);
        lv(LOOP_4MA);
        wb(1'b1, REG_CTRL, 32'h6);
        lv(8'd70);
        pulse(0);
        wb(1'b0, REG_STATUS, 32'h4, 32'h1c);
        wb(1'b1, REG_MODE_CMD, 32'h3);
        lv(8'd30);
        pulse(0);
        wb(1'b1, REG_MODE_CMD, 32'h2);
        lv(8'd70);
        repeat (220) @(posedge clk_i);
        wb(1'b0, REG_STATUS, 32'h4, 32'h1c);
        wb(1'b1, REG_MODE_CMD, 32'h5);
        put(16'sh0032);
        chk(pnl.value, 32'h32);
        put(16'sh012c);
        pulse(1);
        chk(pnl.show, SHOW_FAIL);
        chk(pnl.menu_item, MENU_ZERO_ADJ);
        wb(1'b0, REG_ZERO, 32'h0);
        pulse(0);
        wb(1'b1, REG_CTRL, 32'h3);
        put(16'sh01f4);
        repeat (100) @(posedge clk_i);
        chk(alarm, 32'h0);
        for (n = 0; alarm !== 1'b1 && n < 9000; n++)
            @(posedge clk_i);
        chk(n > 7500, 1'b1);
        put(16'sh0000);
        flt <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(pnl.fault_lamp, 32'h1);
        chk(pnl.fault_code, 32'h27);
        chk(pnl.show, SHOW_ERROR);
        chk(rx_flt, 32'h1);
        lv(LOOP_FAULT);
        flt <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(loop, LOOP_INIT);
        wb(1'b0, REG_STATUS, 32'h0, 32'h1c);
        complete_run();
    end
    // Hang guard: far beyond the longest expected run
    initial begin
        #1000000;
        bad_count++;
        complete_run();
    end
endmodule // test_gas_alarm_state_output_control

bind gas_alarm_state_output_control gas_alarm_state_output_control_monitor
    #(.CYCLES_PER_MS_P(CYCLES_PER_MS_P)) i_mon (.clk_i(clk_i),
    .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .raw_conc_i(raw_conc_i), .temp_out_of_range_i(temp_out_of_range_i),
    .fault_i(fault_i), .panel_o(panel_o), .gas_alarm_o(gas_alarm_o),
    .loop_level_o(loop_level_o));
